// ==== tcc_pkg.sv ====
// Purpose: Constants shared by the 16-bit capture/compare timer channel.
// Assumes: One channel per instance; the channel number picks its register addresses.
// Notes:   Control bits other than the three data registers arrive as plain ports.
//
// How it works
// - Count register increments by one on each count tick while running.
// - Reading the count register holds off the tick so the read is a snapshot.
// - Count forced to 0000H on reset and while run mode is stop.
// - Edge clear-and-start mode zeroes the count on input A valid edge.
// - Match clear-and-start mode zeroes the count when it equals register A.
// - Control bit 0 set makes register A capture, clear makes it compare.
// - Register A resets to 0000H and is written as one 16-bit word.
// - Register A in compare mode raises match request A on equality.
// - Register A capturing from input A uses the edge opposite a single valid edge; with both edges it never captures.
// - Register A capturing from input B uses input B valid edge itself.
// - Register A at zero matches as count wraps FFFFH through 0000H to 0001H.
// - Compare value below count matches only after overflow wraps the count.
// - Read colliding with capture may read stale; stored capture stays correct.
// - Control bit 2 set makes register B capture, clear makes it compare.
// - Register B resets to 0000H and is written as one 16-bit word.
// - Register B in compare mode raises match request B on equality.
// - Register B captures the count on input A valid edge.
// - Register B zero matches after wrap; a B capture also raises request B.
// - Run mode: 00 stop, 01 free, 10 clear on edge, 11 clear on match.
// - Overflow flag sets when register A is FFFFH and count rolls to 0000H.
package tcc_pkg;

  // ****************************************************************
  // Register addresses, per channel
  // ****************************************************************
  localparam logic [15:0] CH0_CAPCOMP_A_ADDR = 16'hff0a;
  localparam logic [15:0] CH0_CAPCOMP_B_ADDR = 16'hff0c;
  localparam logic [15:0] CH0_COUNT_ADDR     = 16'hff0e;
  localparam logic [15:0] CH1_CAPCOMP_A_ADDR = 16'hff68;
  localparam logic [15:0] CH1_CAPCOMP_B_ADDR = 16'hff6a;
  localparam logic [15:0] CH1_COUNT_ADDR     = 16'hff6c;

  // ****************************************************************
  // Reset values and special counts
  // ****************************************************************
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [15:0] CAPCOMP_RST  = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;
  localparam logic [15:0] RDATA_RST    = 16'h0000;

  // ****************************************************************
  // Field positions in the control inputs
  // ****************************************************************
  localparam int A_CAPTURE_SELECT_BIT = 0;
  localparam int A_TRIGGER_SOURCE_BIT = 1;
  localparam int B_CAPTURE_SELECT_BIT = 2;

  typedef enum logic [1:0] {
    TCC_RUN_STOP  = 2'h0,
    TCC_RUN_FREE  = 2'h1,
    TCC_RUN_EDGE  = 2'h2,
    TCC_RUN_MATCH = 2'h3
  } tcc_run_e;

  typedef enum logic [1:0] {
    TCC_EDGE_FALL = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_BAD  = 2'h2,
    TCC_EDGE_BOTH = 2'h3
  } tcc_edge_e;

endpackage : tcc_pkg

// ==== tcc_edge_det.sv ====
// Purpose: Rising and falling edge detector for one timer input pin.
// Assumes: The pin is already synchronous to the clock.
// Notes:   No edge is reported in the first cycle after reset.
`timescale 1ns/1ps
module tcc_edge_det (
  input  wire logic clk_in,    // System clock.
  input  wire logic rst_n_in,  // Asynchronous reset, active low.
  input  wire logic pin_in,    // Timer input pin level.
  output logic      rise_out,  // Rising edge seen this cycle.
  output logic      fall_out   // Falling edge seen this cycle.
);
  logic prev_r;
  logic prev_nxt;
  logic seen_r;
  logic seen_nxt;

  always_comb begin
    prev_nxt = pin_in;
    seen_nxt = 1'b1;
  end

  // A first sample is needed before any edge can be trusted.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign rise_out = seen_r & pin_in & ~prev_r;
  assign fall_out = seen_r & ~pin_in & prev_r;
endmodule : tcc_edge_det

// ==== tcc_timer16.sv ====
// Purpose: One 16-bit timer channel with two capture/compare registers.
// Assumes: count_en_in is a one-cycle pulse per selected count clock edge.
// Notes:   Run mode, capture selects and edge fields are plain input ports.
`timescale 1ns/1ps
module tcc_timer16 import tcc_pkg::*; #(
  parameter int CH = 0
) (
  input  wire logic        clk_in,          // 40 MHz system clock.
  input  wire logic        rst_n_in,        // Asynchronous reset, active low.
  input  wire logic        count_en_in,     // Count clock pulse.
  input  wire logic [1:0]  run_mode_in,     // Run mode field.
  input  wire logic [2:0]  capcomp_ctrl_in, // Capture selects and trigger source.
  input  wire logic [1:0]  edge_a_sel_in,   // Input A valid edge field.
  input  wire logic [1:0]  edge_b_sel_in,   // Input B valid edge field.
  input  wire logic        edge_input_a_in, // Timer input pin A.
  input  wire logic        edge_input_b_in, // Timer input pin B.
  input  wire logic [15:0] addr_in,         // Memory bus address.
  input  wire logic        wr_en_in,        // 16-bit write strobe.
  input  wire logic        rd_en_in,        // 16-bit read strobe.
  input  wire logic [15:0] wdata_in,        // Write data.
  input  wire logic        ovf_clr_in,      // Clears the overflow flag.
  output logic      [15:0] rdata_out,       // Read data, one cycle after strobe.
  output logic             match_irq_a_out, // Request A pulse.
  output logic             match_irq_b_out, // Request B pulse.
  output logic             overflow_flag_out // Overflow detected.
);

  // ****************************************************************
  // Addresses and control decode
  // ****************************************************************
  localparam logic [15:0] A_ADDR = (CH == 0) ? CH0_CAPCOMP_A_ADDR : CH1_CAPCOMP_A_ADDR;
  localparam logic [15:0] B_ADDR = (CH == 0) ? CH0_CAPCOMP_B_ADDR : CH1_CAPCOMP_B_ADDR;
  localparam logic [15:0] C_ADDR = (CH == 0) ? CH0_COUNT_ADDR : CH1_COUNT_ADDR;

  tcc_run_e  run_mode;
  tcc_edge_e edge_a;
  tcc_edge_e edge_b;
  logic      running;
  logic      a_capture_select;
  logic      a_trigger_source;
  logic      b_capture_select;

  assign run_mode         = tcc_run_e'(run_mode_in);
  assign edge_a           = tcc_edge_e'(edge_a_sel_in);
  assign edge_b           = tcc_edge_e'(edge_b_sel_in);
  assign running          = (run_mode != TCC_RUN_STOP);
  assign a_capture_select = capcomp_ctrl_in[A_CAPTURE_SELECT_BIT];
  assign a_trigger_source = capcomp_ctrl_in[A_TRIGGER_SOURCE_BIT];
  assign b_capture_select = capcomp_ctrl_in[B_CAPTURE_SELECT_BIT];

  // ****************************************************************
  // Edge detection on both input pins
  // ****************************************************************
  logic [1:0] pins;
  logic [1:0] rise;
  logic [1:0] fall;

  assign pins = {edge_input_b_in, edge_input_a_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_edge
      tcc_edge_det u_edge (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .pin_in   (pins[gi]),
        .rise_out (rise[gi]),
        .fall_out (fall[gi])
      );
    end
  endgenerate

  // The prohibited field value 10 selects no edge at all.
  logic valid_a;
  logic valid_b;
  logic opp_a;

  always_comb begin
    case (edge_a)
      TCC_EDGE_FALL: valid_a = fall[0];
      TCC_EDGE_RISE: valid_a = rise[0];
      TCC_EDGE_BOTH: valid_a = rise[0] | fall[0];
      default:       valid_a = 1'b0;
    endcase
    case (edge_b)
      TCC_EDGE_FALL: valid_b = fall[1];
      TCC_EDGE_RISE: valid_b = rise[1];
      TCC_EDGE_BOTH: valid_b = rise[1] | fall[1];
      default:       valid_b = 1'b0;
    endcase
    case (edge_a)
      TCC_EDGE_FALL: opp_a = rise[0];
      TCC_EDGE_RISE: opp_a = fall[0];
      default:       opp_a = 1'b0;
    endcase
  end

  // ****************************************************************
  // Counter, capture and compare
  // ****************************************************************
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] cap_a_r;
  logic [15:0] cap_a_nxt;
  logic [15:0] cap_b_r;
  logic [15:0] cap_b_nxt;
  logic        pend_r;
  logic        pend_nxt;
  logic        wrapped_r;
  logic        wrapped_nxt;
  logic        hold;
  logic        tick;
  logic        edge_clear;
  logic        match_a;
  logic        match_b;
  logic        cap_a_evt;
  logic        cap_b_evt;
  logic        irq_a_nxt;
  logic        irq_b_nxt;
  logic        ovf_nxt;
  logic [15:0] rdata_nxt;
  logic        rd_count;

  assign rd_count   = rd_en_in & (addr_in == C_ADDR);
  // A count pulse that lands on a read is deferred, not dropped.
  assign hold       = rd_count;
  assign tick       = running & (count_en_in | pend_r) & ~hold;
  assign edge_clear = (run_mode == TCC_RUN_EDGE) & valid_a;
  // A zero compare value only matches once the count has wrapped.
  assign match_a    = tick & ~a_capture_select & (count_r == cap_a_r)
                      & ((cap_a_r != COUNT_RST) | wrapped_r);
  assign match_b    = tick & ~b_capture_select & (count_r == cap_b_r)
                      & ((cap_b_r != COUNT_RST) | wrapped_r);
  assign cap_a_evt  = a_capture_select & (a_trigger_source ? opp_a : valid_b);
  assign cap_b_evt  = b_capture_select & valid_a;

  always_comb begin
    pend_nxt    = running & (count_en_in | pend_r) & hold;
    count_nxt   = count_r;
    wrapped_nxt = wrapped_r;
    if (!running) begin
      count_nxt   = COUNT_RST;
      wrapped_nxt = 1'b0;
    end else if (edge_clear) begin
      count_nxt   = COUNT_RST;
      wrapped_nxt = 1'b0;
    end else if (tick) begin
      if ((run_mode == TCC_RUN_MATCH) && (count_r == cap_a_r)) begin
        count_nxt = COUNT_RST;
      end else begin
        count_nxt = count_r + COUNT_ONE;
      end
      if (count_r == COUNT_MAX) begin
        wrapped_nxt = 1'b1;
      end
    end
    // Capture beats a same-cycle software write so no event is lost.
    cap_a_nxt = cap_a_r;
    if (cap_a_evt) begin
      cap_a_nxt = count_r;
    end else if (wr_en_in && (addr_in == A_ADDR)) begin
      cap_a_nxt = wdata_in;
    end
    cap_b_nxt = cap_b_r;
    if (cap_b_evt) begin
      cap_b_nxt = count_r;
    end else if (wr_en_in && (addr_in == B_ADDR)) begin
      cap_b_nxt = wdata_in;
    end
    irq_a_nxt = match_a | cap_a_evt;
    irq_b_nxt = match_b | cap_b_evt;
    // Setting wins over a clear arriving in the same cycle.
    ovf_nxt = overflow_flag_out & ~ovf_clr_in;
    if (tick && (count_r == COUNT_MAX) && (cap_a_r == COUNT_MAX)) begin
      ovf_nxt = 1'b1;
    end
    rdata_nxt = rdata_out;
    if (rd_en_in) begin
      case (addr_in)
        A_ADDR:  rdata_nxt = cap_a_r;
        B_ADDR:  rdata_nxt = cap_b_r;
        C_ADDR:  rdata_nxt = count_r;
        default: rdata_nxt = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r           <= COUNT_RST;
      cap_a_r           <= CAPCOMP_RST;
      cap_b_r           <= CAPCOMP_RST;
      pend_r            <= 1'b0;
      wrapped_r         <= 1'b0;
      match_irq_a_out   <= 1'b0;
      match_irq_b_out   <= 1'b0;
      overflow_flag_out <= 1'b0;
      rdata_out         <= RDATA_RST;
    end else begin
      count_r           <= count_nxt;
      cap_a_r           <= cap_a_nxt;
      cap_b_r           <= cap_b_nxt;
      pend_r            <= pend_nxt;
      wrapped_r         <= wrapped_nxt;
      match_irq_a_out   <= irq_a_nxt;
      match_irq_b_out   <= irq_b_nxt;
      overflow_flag_out <= ovf_nxt;
      rdata_out         <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  stop_clears_a: assert property (
    (run_mode == TCC_RUN_STOP) |=> (count_r == COUNT_RST))
    else $error("count not zero after stop");

  count_inc_a: assert property (
    (tick && !edge_clear && run_mode == TCC_RUN_FREE) |=>
      (count_r == 16'($past(count_r) + COUNT_ONE)))
    else $error("count did not advance by one");

  read_hold_a: assert property (
    (rd_count && run_mode == TCC_RUN_FREE) |=>
      (count_r == $past(count_r)) && (rdata_out == $past(count_r)))
    else $error("count moved during read or snapshot wrong");

  read_defer_a: assert property (
    (rd_count && count_en_in && run_mode == TCC_RUN_FREE) ##1
      (!rd_count && run_mode == TCC_RUN_FREE) |=>
      (count_r == 16'($past(count_r, 2) + COUNT_ONE)))
    else $error("deferred count pulse lost");

  edge_clear_a: assert property (
    (run_mode == TCC_RUN_EDGE && valid_a) |=> (count_r == COUNT_RST))
    else $error("edge did not clear count");

  match_clear_a: assert property (
    (tick && run_mode == TCC_RUN_MATCH && count_r == cap_a_r) |=>
      (count_r == COUNT_RST)
      && (match_irq_a_out == (!$past(a_capture_select) || $past(cap_a_evt))))
    else $error("match did not clear count");

  match_irq_a: assert property (
    (tick && !a_capture_select && count_r == cap_a_r && cap_a_r != COUNT_RST)
      |=> match_irq_a_out)
    else $error("match A request missing");

  zero_no_early_a: assert property (
    (run_mode == TCC_RUN_STOP) ##1 (!a_capture_select && cap_a_r == COUNT_RST)
      [*2] |-> !match_irq_a_out)
    else $error("zero compare matched before wrap");

  cap_b_a: assert property (
    cap_b_evt |=> (cap_b_r == $past(count_r)) && match_irq_b_out)
    else $error("capture B wrong or no request");

  cap_a_opp_a: assert property (
    (a_capture_select && a_trigger_source && edge_a == TCC_EDGE_RISE && fall[0])
      |=> (cap_a_r == $past(count_r)))
    else $error("capture A on wrong edge");

  irq_pulse_a: assert property (
    (match_irq_b_out && !b_capture_select && !$past(b_capture_select))
      |=> !match_irq_b_out)
    else $error("request B held longer than one cycle");

  ovf_set_a: assert property (
    (tick && count_r == COUNT_MAX && cap_a_r == COUNT_MAX && !edge_clear)
      |=> overflow_flag_out && count_r == COUNT_RST)
    else $error("overflow flag not set on roll");

  // ****************************************************************
  // Register, request and mode checks
  // ****************************************************************
  // A capture may take the write slot, so write checks exclude that cycle.
  // Request checks leave out capture modes, where a pin edge also pulses.

  a_from_b_a: assert property (
    (a_capture_select && !a_trigger_source && valid_b)
      |=> (cap_a_r == $past(count_r)))
    else $error("capture A from input B missed");

  a_cmp_hold_a: assert property (
    (!a_capture_select && !(wr_en_in && addr_in == A_ADDR)) |=> $stable(cap_a_r))
    else $error("register A changed in compare mode");

  b_cmp_hold_a: assert property (
    (!b_capture_select && !(wr_en_in && addr_in == B_ADDR)) |=> $stable(cap_b_r))
    else $error("register B changed in compare mode");

  b_match_irq_a: assert property (
    (tick && !b_capture_select && count_r == cap_b_r && cap_b_r != COUNT_RST)
      |=> match_irq_b_out)
    else $error("match B request missing");

  b_zero_wrap_a: assert property (
    (tick && !b_capture_select && cap_b_r == COUNT_RST && count_r == COUNT_RST
      && wrapped_r) |=> match_irq_b_out)
    else $error("zero compare B missed after wrap");

  a_zero_wrap_a: assert property (
    (tick && !a_capture_select && cap_a_r == COUNT_RST && count_r == COUNT_RST
      && wrapped_r) |=> match_irq_a_out)
    else $error("zero compare A missed after wrap");

  stop_quiet_a: assert property (
    (run_mode == TCC_RUN_STOP && !a_capture_select) |=> !match_irq_a_out)
    else $error("match request while stopped");

  a_write_a: assert property (
    (wr_en_in && addr_in == A_ADDR && !cap_a_evt) |=> (cap_a_r == $past(wdata_in)))
    else $error("write to register A lost");

  b_write_a: assert property (
    (wr_en_in && addr_in == B_ADDR && !cap_b_evt) |=> (cap_b_r == $past(wdata_in)))
    else $error("write to register B lost");

  a_read_a: assert property (
    (rd_en_in && addr_in == A_ADDR) |=> (rdata_out == $past(cap_a_r)))
    else $error("read of register A wrong");

  bad_edge_a: assert property (
    (edge_a == TCC_EDGE_BAD) |-> !valid_a)
    else $error("prohibited edge field selected an edge");

  ovf_keep_a: assert property (
    (overflow_flag_out && !ovf_clr_in) |=> overflow_flag_out)
    else $error("overflow flag dropped without clear");

  a_pulse_a: assert property (
    (match_irq_a_out && !a_capture_select && !$past(a_capture_select))
      |=> !match_irq_a_out)
    else $error("request A held longer than one cycle");

  free_match_c: cover property (run_mode == TCC_RUN_FREE ##[1:1000] match_irq_a_out);
  wrap_c:       cover property (tick && count_r == COUNT_MAX);
  cap_b_c:      cover property (cap_b_evt ##1 match_irq_b_out);
  read_c:       cover property (rd_count && count_en_in && running);
  edge_clr_c:   cover property (edge_clear ##1 (count_r == COUNT_RST));

endmodule : tcc_timer16

// ==== tcc_pulse_src.sv ====
// Purpose: Model of the external pulse sources on timer input pins A and B.
// Assumes: Levels change just after a rising clock edge.
// Notes:   Push-pull sources, so a pin always shows a driven level.
`timescale 1ns/1ps
module tcc_pulse_src #(
  parameter int HOLD = 2
) (
  input  wire logic clk_in,    // System clock.
  output logic      pin_a_out, // Level on input pin A.
  output logic      pin_b_out  // Level on input pin B.
);
  // ****************************************
  // Level driver
  // ****************************************
  initial begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end

  // Each level is held at least HOLD cycles so a slow source still gives clean edges.
  task automatic drive(input logic sel_b, input logic lvl, input int slow);
    @(posedge clk_in);
    #1;
    if (sel_b) begin
      pin_b_out = lvl;
    end else begin
      pin_a_out = lvl;
    end
    repeat (HOLD + slow) @(posedge clk_in);
    #1;
  endtask
endmodule // tcc_pulse_src

// ==== timer16_capture_compare_test.sv ====
// Purpose: Self-checking bench for one 16-bit capture/compare timer channel.
// Assumes: Channel 0 addresses; inputs change 1 ns after a rising edge.
// Notes:   Captures are taken with the count standing still, so the value is exact.
`timescale 1ns/1ps
module timer16_capture_compare_test
  import tcc_pkg::*;
();
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_in = 1'b0;
  logic        rst_n_in, count_en_in, wr_en_in, rd_en_in, ovf_clr_in, pin_a, pin_b;
  logic [1:0]  run_mode_in, edge_a_sel_in, edge_b_sel_in;
  logic [2:0]  capcomp_ctrl_in;
  logic [15:0] addr_in, wdata_in, rdata_out, d;
  logic        match_irq_a_out, match_irq_b_out, overflow_flag_out;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          irq_a_n = 0;
  int          irq_b_n = 0;
  logic [1:0]  codes [3] = '{2'h0, 2'h1, 2'h3};

  tcc_timer16 #(.CH(0)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .count_en_in(count_en_in),
    .run_mode_in(run_mode_in), .capcomp_ctrl_in(capcomp_ctrl_in),
    .edge_a_sel_in(edge_a_sel_in), .edge_b_sel_in(edge_b_sel_in),
    .edge_input_a_in(pin_a), .edge_input_b_in(pin_b), .addr_in(addr_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .wdata_in(wdata_in),
    .ovf_clr_in(ovf_clr_in), .rdata_out(rdata_out), .match_irq_a_out(match_irq_a_out),
    .match_irq_b_out(match_irq_b_out), .overflow_flag_out(overflow_flag_out)
  );
  // Pins A and B both come from the source model; neither is shared with a timer output here.
  tcc_pulse_src #(.HOLD(2)) src_u (.clk_in(clk_in), .pin_a_out(pin_a), .pin_b_out(pin_b));

  always #12.5 clk_in = ~clk_in;

  // Requests are registered pulses, so counting high samples counts events.
  always @(posedge clk_in) begin
    if (match_irq_a_out === 1'b1) irq_a_n++;
    if (match_irq_b_out === 1'b1) irq_b_n++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    addr_in = a;
    wdata_in = v;
    wr_en_in = 1'b1;
    @(posedge clk_in);
    #1;
    wr_en_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    addr_in = a;
    rd_en_in = 1'b1;
    @(posedge clk_in);
    #1;
    rd_en_in = 1'b0;
    v = rdata_out;
    @(posedge clk_in);
    #1;
  endtask

  task automatic ticks(input int n);
    count_en_in = 1'b1;
    repeat (n) @(posedge clk_in);
    #1;
    count_en_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask

  // Passing through stop clears the count, so each test starts from zero.
  task automatic restart(input logic [1:0] mode, input int n);
    run_mode_in = TCC_RUN_STOP;
    @(posedge clk_in);
    #1;
    run_mode_in = mode;
    @(posedge clk_in);
    #1;
    irq_a_n = 0;
    irq_b_n = 0;
    if (n > 0) ticks(n);
  endtask

  task automatic cap_try(input int k, input logic [1:0] code);
    logic [15:0] ra;
    logic [15:0] n;
    logic        hr;
    logic        hf;
    ra = (k == 2) ? CH0_CAPCOMP_B_ADDR : CH0_CAPCOMP_A_ADDR;
    n = 16'(5 + 4 * k) + {14'h0, code};
    hr = (k == 0) ? (code == 2'h0) : code[0];
    hf = (k == 0) ? (code == 2'h1) : (code != 2'h1);
    capcomp_ctrl_in = (k == 0) ? 3'h3 : ((k == 1) ? 3'h1 : 3'h4);
    edge_a_sel_in = code;
    edge_b_sel_in = code;
    wr(ra, 16'hbeef);
    restart(TCC_RUN_FREE, int'(n));
    src_u.drive(k == 1, 1'b1, 3);
    rd(ra, d);
    chk("capture after rise", d, hr ? n : 16'hbeef);
    src_u.drive(k == 1, 1'b0, 3);
    rd(ra, d);
    chk("capture after fall", d, (hr | hf) ? n : 16'hbeef);
    chk("capture requests", 16'((k == 2) ? irq_b_n : irq_a_n), {15'h0, hr} + {15'h0, hf});
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #(90000 * 25);
    fail_count++;
    test_done();
  end

  initial begin
    {rst_n_in, count_en_in, wr_en_in, rd_en_in, ovf_clr_in} = 5'h0;
    {run_mode_in, edge_a_sel_in, edge_b_sel_in, capcomp_ctrl_in} = 9'h0;
    {addr_in, wdata_in} = 32'h0;
    repeat (8) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    @(posedge clk_in);
    #1;
    rd(CH0_CAPCOMP_A_ADDR, d);
    chk("reg A reset", d, CAPCOMP_RST);
    rd(CH0_CAPCOMP_B_ADDR, d);
    chk("reg B reset", d, CAPCOMP_RST);
    wr(CH0_COUNT_ADDR, 16'h1234);
    rd(CH0_COUNT_ADDR, d);
    chk("count reset, read only", d, COUNT_RST);
    rd(16'hff00, d);
    chk("unmapped read", d, RDATA_RST);
    $display("test registers done");
    wr(CH0_CAPCOMP_A_ADDR, 16'h0005);
    wr(CH0_CAPCOMP_B_ADDR, 16'h0003);
    restart(TCC_RUN_FREE, 10);
    rd(CH0_COUNT_ADDR, d);
    chk("free count", d, 16'h000a);
    chk("match A", 16'(irq_a_n), 16'h0001);
    chk("match B", 16'(irq_b_n), 16'h0001);
    irq_a_n = 0;
    wr(CH0_CAPCOMP_A_ADDR, 16'h0002);
    ticks(5);
    chk("no match below count", 16'(irq_a_n), 16'h0000);
    $display("test compare done");
    restart(TCC_RUN_FREE, 3);
    count_en_in = 1'b1;
    addr_in = CH0_COUNT_ADDR;
    rd_en_in = 1'b1;
    @(posedge clk_in);
    #1;
    {count_en_in, rd_en_in} = 2'h0;
    d = rdata_out;
    chk("snapshot read", d, 16'h0003);
    repeat (3) @(posedge clk_in);
    #1;
    rd(CH0_COUNT_ADDR, d);
    chk("tick kept over read", d, 16'h0004);
    run_mode_in = TCC_RUN_STOP;
    ticks(3);
    rd(CH0_COUNT_ADDR, d);
    chk("stop holds zero", d, COUNT_RST);
    $display("test read and stop done");
    wr(CH0_CAPCOMP_A_ADDR, 16'h0004);
    restart(TCC_RUN_MATCH, 12);
    rd(CH0_COUNT_ADDR, d);
    chk("match clear count", d, 16'h0002);
    chk("match clear requests", 16'(irq_a_n), 16'h0002);
    edge_a_sel_in = TCC_EDGE_RISE;
    restart(TCC_RUN_EDGE, 7);
    src_u.drive(1'b0, 1'b1, 0);
    rd(CH0_COUNT_ADDR, d);
    chk("edge clear", d, COUNT_RST);
    ticks(2);
    src_u.drive(1'b0, 1'b0, 0);
    rd(CH0_COUNT_ADDR, d);
    chk("invalid edge keeps count", d, 16'h0002);
    $display("test clear modes done");
    for (int k = 0; k < 3; k++) begin
      foreach (codes[i]) cap_try(k, codes[i]);
    end
    $display("test capture done");
    {capcomp_ctrl_in, edge_a_sel_in, edge_b_sel_in} = 7'h0;
    wr(CH0_CAPCOMP_A_ADDR, COUNT_MAX);
    wr(CH0_CAPCOMP_B_ADDR, 16'h0000);
    restart(TCC_RUN_FREE, 65537);
    rd(CH0_COUNT_ADDR, d);
    chk("wrapped count", d, COUNT_ONE);
    chk("overflow flag", {15'h0, overflow_flag_out}, 16'h0001);
    chk("match A at max", 16'(irq_a_n), 16'h0001);
    chk("zero match after wrap", 16'(irq_b_n), 16'h0001);
    ovf_clr_in = 1'b1;
    @(posedge clk_in);
    #1;
    ovf_clr_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk("overflow cleared", {15'h0, overflow_flag_out}, 16'h0000);
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    @(posedge clk_in);
    #1;
    rd(CH0_CAPCOMP_A_ADDR, d);
    chk("reg A second reset", d, CAPCOMP_RST);
    rd(CH0_COUNT_ADDR, d);
    chk("count second reset", d, COUNT_RST);
    $display("test overflow and reset done");
    test_done();
  end
endmodule // timer16_capture_compare_test
